// ===== dv/dhh_host.sv
/*
 * Host model: register port master and interrupt service.
 * Assumes read data stand only in the cycle after the strobe.
 */
`include "dhh_consts.svh"

module dhh_host
(
    // Clock
    input wire logic clk_i,
    // Register port
    output dhh_pkg::dhh_req_t req_o,
    input wire logic [31:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // Port idle until the first access
    initial req_o = '0;

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        req_o <= '{1'b1, 1'b0, a, v};
        @(posedge clk_i);
        req_o <= '0;
    endtask

    // Read strobe, data taken after the taking edge
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i);
        req_o <= '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge clk_i);
        req_o <= '0;
        #1;
        v = rdata_i;
    endtask

    task automatic service(input logic [31:0] c, output logic [31:0] f);
        rd(`DHH_A_IFLAG, f);
        wr(`DHH_A_ICTRL, c | 32'h0000_0008);
    endtask

    task automatic hist_reset(input logic [31:0] h);
        wr(`DHH_A_HCTRL, h & 32'hFFFF_FFFE);
        wr(`DHH_A_HCTRL, h | 32'h0000_0001);
    endtask
endmodule

// ===== dv/testbench.sv
/*
 * Self-checking bench of the holdover history and interrupt block.
 * Assumes dhh_host owns the register port.
 */
`include "dhh_consts.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ----
    // Signals
    // ----
    localparam logic [31:0] TW_A = 32'h0001_2340;
    localparam logic [31:0] TW_B = 32'h0005_6780;
    localparam logic [31:0] TW_F = 32'h00AB_CDE0;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    dhh_pkg::dhh_req_t reg_i;
    logic [31:0] rdata_o;
    logic [31:0] loop_tw_i = 32'h0000_0000;
    logic [3:0] mon_flag_i = 4'h0;
    logic dpll_lock_i = 1'b0;
    logic [5:0] live_src = 6'h00;
    logic [31:0] tune_word_o;
    dhh_pkg::dhh_mode_t mode_o;
    logic irq_o;
    dhh_pkg::dhh_pin_t [1:0] stat_o;
    logic [31:0] d;
    int err_count = 0;
    int check_count = 0;

    // Clock
    always #5 clk_i = ~clk_i;

    // ----
    // Design and host
    // ----
    dhh_top i_dut
    (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .reg_i(reg_i),
        .rdata_o(rdata_o),
        .loop_tw_i(loop_tw_i),
        .mon_flag_i(mon_flag_i),
        .dpll_lock_i(dpll_lock_i),
        .crystal_signal_loss_i(live_src[0]),
        .apll_lock_loss_i(live_src[3:1]),
        .dpll_lock_loss_i(live_src[4]),
        .switchover_i(live_src[5]),
        .tune_word_o(tune_word_o),
        .mode_o(mode_o),
        .irq_o(irq_o),
        .stat_o(stat_o)
    );

    dhh_host i_host
    (
        .clk_i(clk_i),
        .req_o(reg_i),
        .rdata_i(rdata_o)
    );

    // ----
    // Checks
    // ----
    task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_b(input logic g, input logic e);
        chk_w({31'h0, g}, {31'h0, e});
    endtask

    task automatic chk_m(input dhh_pkg::dhh_mode_t e);
        chk_w(32'(mode_o), 32'(e));
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        i_host.rd(a, d);
        chk_w(d, e);
    endtask

    // Wait, then step off the edge
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #400_000;
        err_count++;
        test_done();
    end

    // ----
    // Tests
    // ----
    initial
    begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rdc(`DHH_A_HCTRL, 32'h0000_0015);
        rdc(`DHH_A_ICTRL, 32'h0000_0002);
        rdc(8'hFC, 32'h0000_0000);
        i_host.wr(`DHH_A_FREE, TW_F);
        wt(2);
        chk_w(tune_word_o, TW_F);
        // Lock, averaging over two ticks
        i_host.wr(`DHH_A_VCFG, 32'h000F_0002);
        i_host.wr(`DHH_A_HCTRL, 32'h0000_0005);
        @(posedge clk_i) loop_tw_i <= TW_A;
        dpll_lock_i <= 1'b1;
        wt(1200);
        chk_m(dhh_pkg::MODE_LOCKED);
        chk_w(tune_word_o, TW_A);
        // Word changes just before failure
        @(posedge clk_i) loop_tw_i <= TW_B;
        wt(20);
        @(posedge clk_i) mon_flag_i <= 4'h1;
        wt(20);
        chk_m(dhh_pkg::MODE_HOLDOVER);
        chk_w(tune_word_o, TW_A);
        rdc(`DHH_A_HWORD, TW_A);
        // Relock after the validation time
        @(posedge clk_i) mon_flag_i <= 4'h0;
        wt(100);
        chk_m(dhh_pkg::MODE_HOLDOVER);
        wt(210);
        chk_w(tune_word_o, TW_B);
        rdc(`DHH_A_HWORD, TW_A);
        i_host.hist_reset(32'h0000_0005);
        @(posedge clk_i) dpll_lock_i <= 1'b0;
        wt(10);
        chk_w(tune_word_o, TW_F);
        i_host.rd(`DHH_A_STAT, d);
        chk_b(d[3], 1'b0);
        // Store a history, then soft reset
        @(posedge clk_i) dpll_lock_i <= 1'b1;
        wt(1200);
        @(posedge clk_i) mon_flag_i <= 4'h1;
        wt(20);
        chk_w(tune_word_o, TW_B);
        i_host.wr(`DHH_A_HCTRL, 32'h0000_0007);
        wt(3);
        chk_w(tune_word_o, TW_F);
        // Rising edges of every external source
        i_host.wr(`DHH_A_IMASK, 32'h0000_0000);
        i_host.wr(`DHH_A_ICTRL, 32'h0000_000B);
        @(posedge clk_i) live_src <= 6'h3F;
        wt(6);
        rdc(`DHH_A_IFLAG, 32'h0000_00BD);
        chk_b(irq_o, 1'b1);
        chk_b(stat_o[0].val, 1'b1);
        chk_b(stat_o[0].oe_n, 1'b0);
        @(posedge clk_i) live_src <= 6'h00;
        wt(6);
        rdc(`DHH_A_IFLAG, 32'h0000_00BD);
        i_host.wr(`DHH_A_IMASK, 32'h0000_00FF);
        wt(3);
        chk_b(irq_o, 1'b0);
        i_host.wr(`DHH_A_ICTRL, 32'h0000_0007);
        i_host.wr(`DHH_A_IMASK, 32'h0000_0042);
        wt(3);
        chk_b(irq_o, 1'b1);
        i_host.wr(`DHH_A_IMASK, 32'h0000_0000);
        wt(3);
        chk_b(irq_o, 1'b0);
        i_host.wr(`DHH_A_ICTRL, 32'h0000_0003);
        wt(3);
        chk_b(irq_o, 1'b1);
        i_host.service(32'h0000_0003, d);
        chk_w(d, 32'h0000_00BD);
        wt(4);
        chk_b(irq_o, 1'b0);
        rdc(`DHH_A_ICTRL, 32'h0000_0003);
        // Falling edge and open-drain pin
        i_host.wr(`DHH_A_SCFG, 32'h0000_3400);
        i_host.wr(`DHH_A_ICTRL, 32'h0000_0001);
        @(posedge clk_i) live_src <= 6'h01;
        wt(6);
        chk_b(stat_o[1].oe_n, 1'b0);
        chk_b(stat_o[1].val, 1'b0);
        rdc(`DHH_A_IFLAG, 32'h0000_0000);
        @(posedge clk_i) live_src <= 6'h00;
        wt(6);
        chk_b(stat_o[1].oe_n, 1'b1);
        rdc(`DHH_A_IFLAG, 32'h0000_0001);
        test_done();
    end
endmodule

// ===== verilog/dhh_consts.svh
/*
 * Constants of the DPLL holdover history and interrupt block.
 * Assumes a 100 MHz system clock and word-aligned register offsets.
 */
//
// Contract
// - tuning word from loop, history or free-run
// - accumulate loop output while enabled and locked
// - store final average when reference becomes invalid; code stores the average before the latest one
// - drop running and latest average on failure
// - hard or soft reset clears history
// - first stored word only after first interval; code stores none before two intervals complete
// - history kept over switchover and holdover exit
// - enable one-zero-one sequence clears history
// - no history means holdover uses free-run word
// - status pins: source, driver type, polarity selectable
// - listed event sources can raise the interrupt
// - polarity picks rising or falling flag edge
// - each flag masked individually from interrupt
// - unmasked flags combined by AND or OR
// - writing one to clear field drops interrupt
// - reference valid after monitors clear validation time
`ifndef DHH_CONSTS_SVH
`define DHH_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define DHH_CLK_NS 10
`define DHH_TICK_NS 1000
`define DHH_TICK_CYC (`DHH_TICK_NS / `DHH_CLK_NS)
`define DHH_TICK_W 7

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DHH_A_HCTRL 8'h00
`define DHH_A_FREE 8'h04
`define DHH_A_VCFG 8'h08
`define DHH_A_STAT 8'h0C
`define DHH_A_HWORD 8'h10
`define DHH_A_TUNE 8'h14
`define DHH_A_ICTRL 8'h18
`define DHH_A_IFLAG 8'h1C
`define DHH_A_IMASK 8'h20
`define DHH_A_SCFG 8'h24

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define DHH_B_HEN 0
`define DHH_B_SRST 1
`define DHH_F_TMR 6:2
`define DHH_F_VTIME 15:0
`define DHH_F_MEN 19:16
`define DHH_B_IEN 0
`define DHH_B_IPOL 1
`define DHH_B_IAND 2
`define DHH_B_ICLR 3
`define DHH_SCFG_STRIDE 8
`define DHH_SCFG_POL 4
`define DHH_SCFG_OD 5
`define DHH_SCFG_W 14
`define DHH_RST_HCTRL 32'h0000_0015
`define DHH_ZERO 32'h0000_0000
`define DHH_NSRC 8
`define DHH_NMON 4
`define DHH_NASYNC 11

`endif

// ===== verilog/dhh_irq_flag.sv
/*
 * One sticky interrupt flag with edge selection.
 * Assumes live level is already in the clock domain.
 */
module dhh_irq_flag
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic live_i,
    input wire logic pol_i,
    input wire logic en_i,
    input wire logic clr_i,
    // Flag
    output logic flag_o
);

    logic live_d;
    logic hit;

    assign hit = en_i && (pol_i ? (live_i && !live_d) : (!live_i && live_d));

    // Previous live level
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            live_d <= 1'b0;
        else
            live_d <= live_i;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            flag_o <= 1'b0;
        else if (hit)
            flag_o <= 1'b1;
        else if (clr_i)
            flag_o <= 1'b0;
    end

    a_flag_sticky:
    assert property (@(posedge clk_i) disable iff (sys_rst_i)
        flag_o && !clr_i |=> flag_o)
    else $error("sticky flag dropped without clear");

endmodule

// ===== verilog/dhh_pkg.sv
/*
 * Types of the DPLL holdover history and interrupt block.
 * Assumes dhh_consts.svh supplies every numeric constant.
 */
package dhh_pkg;

    // Operating mode, Gray coded along free-run, locked, holdover
    typedef enum logic [1:0]
    {
        MODE_FREERUN = 2'h0,
        MODE_LOCKED = 2'h1,
        MODE_HOLDOVER = 2'h3
    } dhh_mode_t;

    // One register port request
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } dhh_req_t;

    // Three-state status pin drive
    typedef struct packed
    {
        logic val;
        logic oe_n;
    } dhh_pin_t;

endpackage

// ===== verilog/dhh_sync2.sv
/*
 * Two-stage synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level, not a multi-bit word.
 */
module dhh_sync2
#(
    parameter int W = 1
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta;

    // First stage read only by second stage
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            meta <= '0;
            q_o <= '0;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end

endmodule

// ===== verilog/dhh_top.sv
/*
 * DPLL tuning word selection, averaged history, reference
 * validation, status pin routing and interrupt aggregation.
 * Assumes loop filter word on clk_i; monitor and lock levels async.
 */
`include "dhh_consts.svh"

module dhh_top
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire dhh_pkg::dhh_req_t reg_i,
    output logic [31:0] rdata_o,
    // Loop filter and monitors
    input wire logic [31:0] loop_tw_i,
    input wire logic [`DHH_NMON-1:0] mon_flag_i,
    input wire logic dpll_lock_i,
    input wire logic crystal_signal_loss_i,
    input wire logic [2:0] apll_lock_loss_i,
    input wire logic dpll_lock_loss_i,
    input wire logic switchover_i,
    // Results
    output logic [31:0] tune_word_o,
    output dhh_pkg::dhh_mode_t mode_o,
    output logic irq_o,
    output dhh_pkg::dhh_pin_t [1:0] stat_o
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [`DHH_NASYNC-1:0] async_s;
    logic [`DHH_NMON-1:0] mon_s;
    logic lock_s;
    logic los_s;
    logic [2:0] alol_s;
    logic dlol_s;
    logic swo_s;
    logic [`DHH_TICK_W-1:0] tick_cnt;
    logic tick;
    logic hist_en;
    logic [4:0] tmr_exp;
    logic soft_rst;
    logic [31:0] free_run;
    logic [31:0] vcfg;
    logic int_en;
    logic int_pol;
    logic int_and;
    logic interrupt_clear_field;
    logic [`DHH_NSRC-1:0] mask;
    logic [`DHH_SCFG_W-1:0] scfg;
    logic [15:0] vcnt;
    logic ref_valid;
    logic ref_valid_d;
    logic ref_fail;
    logic mon_act;
    dhh_pkg::dhh_mode_t state;
    dhh_pkg::dhh_mode_t next_state;
    logic [63:0] acc;
    logic [63:0] acc_sum;
    logic [63:0] avg_full;
    logic [31:0] scnt;
    logic [31:0] ivl_len;
    logic ivl_end;
    logic [1:0] n_avg;
    logic [31:0] avg_last;
    logic [31:0] avg_prev;
    logic [31:0] hist_word;
    logic hist_exists;
    logic [`DHH_NSRC-1:0] live;
    logic [`DHH_NSRC-1:0] flags;
    logic [`DHH_NSRC-1:0] w1c;
    logic next_irq;
    logic [15:0] stat_src;
    logic wr_hctrl;
    logic wr_ictrl;
    // Reset image of history control, sliced per field
    localparam logic [31:0] rst_hctrl = `DHH_RST_HCTRL;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    dhh_sync2 #(.W(`DHH_NASYNC)) u_sync
    (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i({mon_flag_i, dpll_lock_i, crystal_signal_loss_i,
              apll_lock_loss_i, dpll_lock_loss_i, switchover_i}),
        .q_o(async_s)
    );

    // Split synchronised levels
    assign {mon_s, lock_s, los_s, alol_s, dlol_s, swo_s} = async_s;

    // ----------------------------------------
    // Microsecond tick divider
    // ----------------------------------------
    // Tick enable once per microsecond
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end
        else if (tick_cnt == `DHH_TICK_W'(`DHH_TICK_CYC - 1))
        begin
            tick_cnt <= '0;
            tick <= 1'b1;
        end
        else
        begin
            tick_cnt <= tick_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    assign wr_hctrl = reg_i.wr && reg_i.addr == `DHH_A_HCTRL;
    assign wr_ictrl = reg_i.wr && reg_i.addr == `DHH_A_ICTRL;

    // History control and self-clearing soft reset
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            hist_en <= rst_hctrl[`DHH_B_HEN];
            tmr_exp <= rst_hctrl[`DHH_F_TMR];
            soft_rst <= 1'b0;
        end
        else
        begin
            soft_rst <= wr_hctrl && reg_i.wdata[`DHH_B_SRST];
            if (wr_hctrl)
            begin
                hist_en <= reg_i.wdata[`DHH_B_HEN];
                tmr_exp <= reg_i.wdata[`DHH_F_TMR];
            end
        end
    end

    // Interrupt control and self-clearing clear field
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            int_en <= 1'b0;
            int_pol <= 1'b1;
            int_and <= 1'b0;
            interrupt_clear_field <= 1'b0;
        end
        else
        begin
            interrupt_clear_field <= wr_ictrl && reg_i.wdata[`DHH_B_ICLR];
            if (wr_ictrl)
            begin
                int_en <= reg_i.wdata[`DHH_B_IEN];
                int_pol <= reg_i.wdata[`DHH_B_IPOL];
                int_and <= reg_i.wdata[`DHH_B_IAND];
            end
        end
    end

    // Plain configuration words
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            free_run <= `DHH_ZERO;
            vcfg <= `DHH_ZERO;
            mask <= '0;
            scfg <= '0;
        end
        else if (reg_i.wr)
        begin
            if (reg_i.addr == `DHH_A_FREE)
                free_run <= reg_i.wdata;
            if (reg_i.addr == `DHH_A_VCFG)
                vcfg <= reg_i.wdata;
            if (reg_i.addr == `DHH_A_IMASK)
                mask <= reg_i.wdata[`DHH_NSRC-1:0];
            if (reg_i.addr == `DHH_A_SCFG)
                scfg <= reg_i.wdata[`DHH_SCFG_W-1:0];
        end
    end

    // ----------------------------------------
    // Reference validation
    // ----------------------------------------
    assign mon_act = |(mon_s & vcfg[`DHH_F_MEN]);
    assign ref_fail = ref_valid_d && !ref_valid;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            vcnt <= '0;
            ref_valid <= 1'b0;
        end
        else if (mon_act)
        begin
            vcnt <= '0;
            ref_valid <= 1'b0;
        end
        else if (tick)
        begin
            if (vcnt >= vcfg[`DHH_F_VTIME])
                ref_valid <= 1'b1;
            else
                vcnt <= vcnt + 1'b1;
        end
    end

    // Previous validity for failure edge
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            ref_valid_d <= 1'b0;
        else
            ref_valid_d <= ref_valid;
    end

    a_ref_invalid:
    assert property (mon_act |=> !ref_valid)
    else $error("reference valid while monitor flag active");

    // ----------------------------------------
    // Operating mode
    // ----------------------------------------
    // Next mode from lock and validity
    always_comb
    begin
        next_state = state;
        unique case (state)
            dhh_pkg::MODE_FREERUN, dhh_pkg::MODE_HOLDOVER:
                if (lock_s && ref_valid)
                    next_state = dhh_pkg::MODE_LOCKED;
            dhh_pkg::MODE_LOCKED:
                if (!lock_s || !ref_valid)
                    next_state = dhh_pkg::MODE_HOLDOVER;
            default:
                next_state = dhh_pkg::MODE_FREERUN;
        endcase
    end

    // Mode register
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            state <= dhh_pkg::MODE_FREERUN;
        else
            state <= next_state;
    end

    assign mode_o = state;

    // ----------------------------------------
    // History accumulation
    // ----------------------------------------
    assign acc_sum = acc + {32'h0000_0000, loop_tw_i};
    assign avg_full = acc_sum >> tmr_exp;
    assign ivl_len = 32'h0000_0001 << tmr_exp;
    assign ivl_end = tick && scnt == ivl_len - 32'h0000_0001;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            acc <= '0;
            scnt <= '0;
            n_avg <= '0;
            avg_last <= `DHH_ZERO;
            avg_prev <= `DHH_ZERO;
        end
        else if (soft_rst || !hist_en || state != dhh_pkg::MODE_LOCKED)
        begin
            acc <= '0;
            scnt <= '0;
            n_avg <= '0;
        end
        else if (ivl_end)
        begin
            acc <= '0;
            scnt <= '0;
            avg_last <= avg_full[31:0];
            avg_prev <= avg_last;
            if (n_avg != 2'h2)
                n_avg <= n_avg + 1'b1;
        end
        else if (tick)
        begin
            acc <= acc_sum;
            scnt <= scnt + 32'h0000_0001;
        end
    end

    // ----------------------------------------
    // Stored history
    // ----------------------------------------
    // cleared by resets and enable low
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            hist_word <= `DHH_ZERO;
            hist_exists <= 1'b0;
        end
        else if (soft_rst || !hist_en)
        begin
            hist_word <= `DHH_ZERO;
            hist_exists <= 1'b0;
        end
        else if (ref_fail && n_avg == 2'h2)
        begin
            hist_word <= avg_prev;
            hist_exists <= 1'b1;
        end
    end

    sequence s_fail_full;
        ref_fail && n_avg == 2'h2 && hist_en && !soft_rst;
    endsequence

    sequence s_fail_short;
        ref_fail && n_avg != 2'h2;
    endsequence

    a_hist_store:
    assert property (s_fail_full |=> hist_exists
        && hist_word == $past(avg_prev))
    else $error("history not taken from older average");

    a_hist_keep:
    assert property (s_fail_short ##0 (hist_en && !soft_rst)
        |=> $stable(hist_word) && $stable(hist_exists))
    else $error("history changed without full average");

    a_hist_enclr:
    assert property (!hist_en |=> !hist_exists ##1 !hist_exists)
    else $error("history survives enable low");

    a_soft_clear:
    assert property (soft_rst |=> hist_word == `DHH_ZERO)
    else $error("soft reset left history");

    // ----------------------------------------
    // Tuning word output
    // ----------------------------------------
    // source by mode
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            tune_word_o <= `DHH_ZERO;
        else
        begin
            unique case (state)
                dhh_pkg::MODE_LOCKED:
                    tune_word_o <= loop_tw_i;
                dhh_pkg::MODE_HOLDOVER:
                    tune_word_o <= hist_exists ? hist_word : free_run;
                default:
                    tune_word_o <= free_run;
            endcase
        end
    end

    a_tune_lock:
    assert property (state == dhh_pkg::MODE_LOCKED
        |=> tune_word_o == $past(loop_tw_i))
    else $error("locked mode not using loop filter word");

    a_tune_nohist:
    assert property (state == dhh_pkg::MODE_HOLDOVER && !hist_exists
        |=> tune_word_o == $past(free_run))
    else $error("holdover without history not free-run");

    // ----------------------------------------
    // Interrupt flags
    // ----------------------------------------
    // event sources
    assign live = {swo_s, state == dhh_pkg::MODE_HOLDOVER, dlol_s,
                   alol_s, !ref_valid, los_s};

    assign w1c = ({`DHH_NSRC{reg_i.wr && reg_i.addr == `DHH_A_IFLAG}}
                  & reg_i.wdata[`DHH_NSRC-1:0]) | {`DHH_NSRC{interrupt_clear_field}};

    // One sticky flag per source
    for (genvar g = 0; g < `DHH_NSRC; g++)
    begin : g_flag
        dhh_irq_flag u_flag
        (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .live_i(live[g]),
            .pol_i(int_pol),
            .en_i(int_en),
            .clr_i(w1c[g]),
            .flag_o(flags[g])
        );
    end

    assign next_irq = int_en && (int_and
        ? ((|(~mask)) && (&(flags | mask)))
        : (|(flags & ~mask)));

    // Registered interrupt level
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= next_irq;
    end

    a_irq_masked:
    assert property (!int_and && (flags & ~mask) == '0 |=> !irq_o)
    else $error("interrupt raised by masked flags");

    a_irq_gate:
    assert property (!int_en |=> !irq_o)
    else $error("interrupt while logic disabled");

    // ----------------------------------------
    // Status pins
    // ----------------------------------------
    assign stat_src = {4'h0, swo_s, state == dhh_pkg::MODE_LOCKED,
                       state == dhh_pkg::MODE_HOLDOVER, dlol_s, alol_s,
                       los_s, lock_s, hist_exists, ref_valid, irq_o};

    for (genvar p = 0; p < 2; p++)
    begin : g_pin
        logic [3:0] sel;
        logic lvl;
        logic od;
        assign sel = scfg[p*`DHH_SCFG_STRIDE +: 4];
        assign od = scfg[p*`DHH_SCFG_STRIDE + `DHH_SCFG_OD];
        assign lvl = stat_src[sel]
                     ^ scfg[p*`DHH_SCFG_STRIDE + `DHH_SCFG_POL];

        // Open drain pulls low only
        always_ff @(posedge clk_i or posedge sys_rst_i)
        begin
            if (sys_rst_i)
            begin
                stat_o[p].val <= 1'b0;
                stat_o[p].oe_n <= 1'b1;
            end
            else
            begin
                stat_o[p].val <= od ? 1'b0 : lvl;
                stat_o[p].oe_n <= od ? lvl : 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    // Read data one cycle after strobe
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            rdata_o <= `DHH_ZERO;
        else if (!reg_i.rd)
            rdata_o <= `DHH_ZERO;
        else
        begin
            unique case (reg_i.addr)
                `DHH_A_HCTRL:
                    rdata_o <= {25'h0, tmr_exp, 1'b0, hist_en};
                `DHH_A_FREE:
                    rdata_o <= free_run;
                `DHH_A_VCFG:
                    rdata_o <= {12'h000, vcfg[19:0]};
                `DHH_A_STAT:
                    rdata_o <= {27'h0, lock_s, hist_exists, ref_valid,
                                state};
                `DHH_A_HWORD:
                    rdata_o <= hist_word;
                `DHH_A_TUNE:
                    rdata_o <= tune_word_o;
                `DHH_A_ICTRL:
                    rdata_o <= {29'h0, int_and, int_pol, int_en};
                `DHH_A_IFLAG:
                    rdata_o <= {24'h00_0000, flags};
                `DHH_A_IMASK:
                    rdata_o <= {24'h00_0000, mask};
                `DHH_A_SCFG:
                    rdata_o <= {18'h0_0000, scfg};
                default:
                    rdata_o <= `DHH_ZERO;
            endcase
        end
    end

    a_clr_reads0:
    assert property (reg_i.rd && reg_i.addr == `DHH_A_ICTRL
        |=> rdata_o[`DHH_B_ICLR] == 1'b0)
    else $error("clear field read back as one");

endmodule
